// [include/afrc_pkg.sv]
package afrc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int REG_W       = 10;
    localparam int ADDR_W      = 4;
    localparam int NUM_REGS    = 13;
    localparam int FRAME_BITS  = 16;
    localparam int WORD_W      = 16;
    localparam int DOUT_W      = 8;
    localparam int NUM_CH      = 3;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_RED_GAIN     = 4'h0;
    localparam logic [3:0] ADDR_GREEN_GAIN   = 4'h1;
    localparam logic [3:0] ADDR_BLUE_GAIN    = 4'h2;
    localparam logic [3:0] ADDR_RED_OFFSET   = 4'h3;
    localparam logic [3:0] ADDR_GREEN_OFFSET = 4'h4;
    localparam logic [3:0] ADDR_BLUE_OFFSET  = 4'h5;
    localparam logic [3:0] ADDR_MODE_PRIMARY = 4'h6;
    localparam logic [3:0] ADDR_MODE_SECOND  = 4'h7;
    localparam logic [3:0] ADDR_BLACK_DELAY  = 4'h8;
    localparam logic [3:0] ADDR_VIDEO_DELAY  = 4'h9;
    localparam logic [3:0] ADDR_ADC_DELAY    = 4'ha;
    localparam logic [3:0] ADDR_FACTORY_TEST = 4'hb;
    localparam logic [3:0] ADDR_RESET_READ   = 4'hc;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [9:0] REG_RST_VAL  = 10'h000;
    localparam logic [9:0] TEST_RST_VAL = 10'h000;
    localparam logic [1:0] MUX_RED      = 2'h0;
    localparam logic [1:0] MUX_GREEN    = 2'h1;
    localparam logic [1:0] MUX_BLUE     = 2'h2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RR_RESET_BIT   = 9;
    localparam int RR_READ_BIT    = 8;
    localparam int RR_PTR_LSB     = 0;
    localparam int M1_CLAMP_BIT   = 5;
    localparam int M1_CIS_BIT     = 4;
    localparam int M1_NIBBLE_BIT  = 3;
    localparam int M1_CR_LSB      = 0;
    localparam int FR_ADDR_LSB    = 12;
    localparam int OFS_COARSE_LSB = 8;
    localparam int OFS_SIGN_BIT   = 7;
    localparam int OFS_MAG_LSB    = 0;
    localparam logic [2:0] CR_HIZ_CODE = 3'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SOFT_RST_NS      = 10;
    localparam int RST_PHASE_DLY_NS = 10;
    localparam int SOFT_RST_CYC_RAW =
        (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SOFT_RST_CYC =
        (SOFT_RST_CYC_RAW < 1) ? 1 : SOFT_RST_CYC_RAW;
    localparam int RST_PHASE_DLY_RAW =
        (RST_PHASE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_PHASE_DLY_CYC =
        (RST_PHASE_DLY_RAW < 1) ? 1 : RST_PHASE_DLY_RAW;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [3:0][8:0] afrc_coarse_lut_t;

    // Codes 0..3 -> 0, -100, +100, +200 mV (signed 9-bit)
    localparam afrc_coarse_lut_t COARSE_LUT_DEF =
        {9'h0c8, 9'h064, 9'h19c, 9'h000};

    typedef struct packed {
        logic [8:0] coarse_mv;
        logic       fine_neg;
        logic [6:0] fine_mag;
    } afrc_offset_t;

    typedef struct packed {
        logic       soft_reset;
        logic       read_en;
        logic [3:0] pointer;
    } afrc_rr_t;

endpackage

// [rtl/afrc_ctrl.sv]
`timescale 1ns/10ps

module afrc_ctrl #(
    parameter afrc_pkg::afrc_coarse_lut_t COARSE_LUT = afrc_pkg::COARSE_LUT_DEF
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_sys_rst,
    input  wire logic                    i_serial_load_n,
    input  wire logic                    i_serial_clk,
    input  wire logic                    i_serial_data_in,
    input  wire logic                    i_black_level_sample_strobe,
    input  wire logic                    i_video_sample_strobe,
    input  wire logic                    i_line_clamp_gate,
    input  wire logic                    i_adc_clk,
    input  wire logic [7:0]              i_conv_data,
    output logic      [7:0]              o_data_out,
    output logic      [1:0]              o_input_mux_sel,
    output logic                         o_reset_switch_a,
    output logic                         o_reset_switch_b,
    output logic                         o_reference_switch_a,
    output logic                         o_reference_switch_b,
    output logic                         o_video_track,
    output logic                         o_clamp_phase,
    output logic                         o_clamp_switch,
    output logic                         o_cr_dac_hiz,
    output logic      [2:0]              o_cr_dac_code,
    output afrc_pkg::afrc_offset_t [2:0] o_offset
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [9:0]  regs_r [afrc_pkg::NUM_REGS];
    logic [15:0] shift_r;
    logic [4:0]  bit_cnt_r;
    logic        sclk_d_r;
    logic        load_n_d_r;
    logic        sclk_rise;
    logic        load_rise;
    logic        wr_en;
    logic [3:0]  wr_addr;
    logic [9:0]  wr_data;
    logic [1:0]  srst_cnt_r;
    logic        srst_active;
    afrc_pkg::afrc_rr_t rr;
    logic [9:0]  mode1;
    logic        nibble_mode;
    logic        line_clamp;
    logic        cis_mode;
    logic [15:0] rb_word;
    logic [15:0] rb_word_r;
    logic [1:0]  lane_r;
    logic [1:0]  lane_last;
    logic        adc_d_r;
    logic        adc_rise;
    logic        black_d_r;
    logic        video_d_r;
    logic        black_rise;
    logic        video_fall;
    logic        rst_phase_r;
    logic [1:0]  rst_dly_r;
    logic        clamp_nxt;

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    assign rr.soft_reset = regs_r[afrc_pkg::ADDR_RESET_READ]
                                 [afrc_pkg::RR_RESET_BIT];
    assign rr.read_en    = regs_r[afrc_pkg::ADDR_RESET_READ]
                                 [afrc_pkg::RR_READ_BIT];
    assign rr.pointer    = regs_r[afrc_pkg::ADDR_RESET_READ]
                                 [afrc_pkg::RR_PTR_LSB +: 4];
    assign mode1         = regs_r[afrc_pkg::ADDR_MODE_PRIMARY];
    assign nibble_mode   = mode1[afrc_pkg::M1_NIBBLE_BIT];
    assign line_clamp    = mode1[afrc_pkg::M1_CLAMP_BIT];
    assign cis_mode      = mode1[afrc_pkg::M1_CIS_BIT];
    assign srst_active   = (srst_cnt_r != 2'h0);

    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    assign sclk_rise = i_serial_clk & ~sclk_d_r;
    assign load_rise = i_serial_load_n & ~load_n_d_r;
    assign wr_en     = load_rise & bit_cnt_r[4] & ~srst_active;
    assign wr_addr   = shift_r[afrc_pkg::FR_ADDR_LSB +: 4];
    assign wr_data   = shift_r[9:0];

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            sclk_d_r   <= 1'b0;
            load_n_d_r <= 1'b1;
        end
        else
        begin
            sclk_d_r   <= i_serial_clk;
            load_n_d_r <= i_serial_load_n;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            shift_r   <= 16'h0000;
            bit_cnt_r <= 5'h00;
        end
        else if (srst_active)
        begin
            shift_r   <= 16'h0000;
            bit_cnt_r <= 5'h00;
        end
        else if (load_rise)
        begin
            bit_cnt_r <= 5'h00;
        end
        else if (!i_serial_load_n && sclk_rise)
        begin
            shift_r <= {shift_r[14:0], i_serial_data_in};
            if (!bit_cnt_r[4])
            begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Register file and soft reset
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            srst_cnt_r <= 2'h0;
        end
        else if (wr_en && wr_addr == afrc_pkg::ADDR_RESET_READ
                 && wr_data[afrc_pkg::RR_RESET_BIT])
        begin
            srst_cnt_r <= 2'(afrc_pkg::SOFT_RST_CYC);
        end
        else if (srst_active)
        begin
            srst_cnt_r <= srst_cnt_r - 2'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            for (int i = 0; i < afrc_pkg::NUM_REGS; i++)
            begin
                regs_r[i] <= afrc_pkg::REG_RST_VAL;
            end
            regs_r[afrc_pkg::ADDR_FACTORY_TEST] <=
                afrc_pkg::TEST_RST_VAL;
        end
        else if (srst_active)
        begin
            for (int i = 0; i < afrc_pkg::NUM_REGS; i++)
            begin
                regs_r[i] <= afrc_pkg::REG_RST_VAL;
            end
            regs_r[afrc_pkg::ADDR_FACTORY_TEST] <=
                afrc_pkg::TEST_RST_VAL;
        end
        else if (wr_en && wr_addr < 4'(afrc_pkg::NUM_REGS))
        begin
            regs_r[wr_addr] <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // Input multiplexer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_input_mux_sel <= afrc_pkg::MUX_RED;
        end
        else if (srst_active)
        begin
            o_input_mux_sel <= afrc_pkg::MUX_RED;
        end
        else if (black_rise)
        begin
            case (o_input_mux_sel)
                afrc_pkg::MUX_RED:   o_input_mux_sel <= afrc_pkg::MUX_GREEN;
                afrc_pkg::MUX_GREEN: o_input_mux_sel <= afrc_pkg::MUX_BLUE;
                default:             o_input_mux_sel <= afrc_pkg::MUX_RED;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Readback serialiser
    // ------------------------------------------------------------
    always_comb
    begin
        if (rr.pointer < 4'(afrc_pkg::NUM_REGS))
        begin
            rb_word = {6'h00, regs_r[rr.pointer]};
        end
        else
        begin
            rb_word = 16'h0000;
        end
    end

    assign adc_rise  = i_adc_clk & ~adc_d_r;
    assign lane_last = nibble_mode ? 2'h3 : 2'h1;

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            adc_d_r   <= 1'b0;
            lane_r    <= 2'h0;
            rb_word_r <= 16'h0000;
        end
        else
        begin
            adc_d_r <= i_adc_clk;
            if (!rr.read_en)
            begin
                lane_r    <= 2'h0;
                rb_word_r <= rb_word;
            end
            else if (adc_rise)
            begin
                if (lane_r >= lane_last)
                begin
                    lane_r    <= 2'h0;
                    rb_word_r <= rb_word;
                end
                else
                begin
                    lane_r <= lane_r + 2'h1;
                end
            end
            else if (lane_r == 2'h0)
            begin
                rb_word_r <= rb_word;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_data_out <= 8'h00;
        end
        else if (!rr.read_en)
        begin
            o_data_out <= i_conv_data;
        end
        else if (nibble_mode)
        begin
            o_data_out <= {4'h0, rb_word_r[4'(15 - 4 * lane_r) -: 4]};
        end
        else
        begin
            o_data_out <= lane_r[0] ? rb_word_r[7:0]
                                    : rb_word_r[15:8];
        end
    end

    // ------------------------------------------------------------
    // Sampling phases
    // ------------------------------------------------------------
    assign black_rise = i_black_level_sample_strobe & ~black_d_r;
    assign video_fall = ~i_video_sample_strobe & video_d_r;

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            black_d_r   <= 1'b0;
            video_d_r   <= 1'b0;
            rst_phase_r <= 1'b1;
            rst_dly_r   <= 2'h0;
        end
        else
        begin
            black_d_r <= i_black_level_sample_strobe;
            video_d_r <= i_video_sample_strobe;
            if (black_rise)
            begin
                rst_phase_r <= 1'b1;
                rst_dly_r   <= 2'h0;
            end
            else if (video_fall)
            begin
                rst_dly_r <= 2'(afrc_pkg::RST_PHASE_DLY_CYC);
            end
            else if (rst_dly_r != 2'h0)
            begin
                rst_dly_r <= rst_dly_r - 2'h1;
                if (rst_dly_r == 2'h1)
                begin
                    rst_phase_r <= 1'b0;
                end
            end
        end
    end

    assign clamp_nxt = line_clamp
        ? (i_line_clamp_gate & i_black_level_sample_strobe)
        : i_black_level_sample_strobe;

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_reset_switch_a     <= 1'b1;
            o_reset_switch_b     <= 1'b1;
            o_reference_switch_a <= 1'b0;
            o_reference_switch_b <= 1'b0;
            o_video_track        <= 1'b0;
            o_clamp_phase        <= 1'b0;
            o_clamp_switch       <= 1'b0;
            o_cr_dac_hiz         <= 1'b0;
            o_cr_dac_code        <= 3'h0;
        end
        else
        begin
            o_reset_switch_a     <= rst_phase_r;
            o_reset_switch_b     <= rst_phase_r;
            o_reference_switch_a <= i_black_level_sample_strobe;
            o_reference_switch_b <= i_black_level_sample_strobe;
            o_video_track        <= i_video_sample_strobe;
            o_clamp_phase        <= clamp_nxt;
            o_clamp_switch       <= clamp_nxt & ~cis_mode;
            o_cr_dac_code        <= mode1[afrc_pkg::M1_CR_LSB +: 3];
            o_cr_dac_hiz         <= cis_mode
                && mode1[afrc_pkg::M1_CR_LSB +: 3]
                   == afrc_pkg::CR_HIZ_CODE;
        end
    end

    // ------------------------------------------------------------
    // Per-channel offset decode
    // ------------------------------------------------------------
    for (genvar ch = 0; ch < afrc_pkg::NUM_CH; ch++)
    begin : g_ofs
        logic [9:0] ofs;
        assign ofs = regs_r[afrc_pkg::ADDR_RED_OFFSET + 4'(ch)];
        always_ff @(posedge i_clk or posedge i_sys_rst)
        begin
            if (i_sys_rst)
            begin
                o_offset[ch] <= '0;
            end
            else
            begin
                o_offset[ch].coarse_mv <=
                    COARSE_LUT[ofs[afrc_pkg::OFS_COARSE_LSB +: 2]];
                o_offset[ch].fine_neg <=
                    ofs[afrc_pkg::OFS_SIGN_BIT];
                o_offset[ch].fine_mag <=
                    ofs[afrc_pkg::OFS_MAG_LSB +: 7];
            end
        end
    end

endmodule

// [sim/afrc_ctrl_host.sv]
`timescale 1ns/10ps
module afrc_ctrl_host (
    input  wire logic i_clk,
    output logic      o_load_n,
    output logic      o_sclk,
    output logic      o_sdi
);
    initial
    begin
        o_load_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end

    // ------------------------------------------------------------
    // Serial register write
    // ------------------------------------------------------------
    task automatic write_reg(input logic [3:0] addr, input logic [9:0] d);
        logic [15:0] frame;
        frame = {addr, 2'b00, d};
        if (addr == afrc_pkg::ADDR_FACTORY_TEST)
            return;
        o_load_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            o_sdi = frame[i];
            o_sclk = 1'b0;
            @(negedge i_clk);
            o_sclk = 1'b1;
            @(negedge i_clk);
        end
        o_sclk = 1'b0;
        o_load_n = 1'b1;
        o_sdi = ~o_sdi;
        @(negedge i_clk);
        @(negedge i_clk);
    endtask
endmodule

// [sim/afrc_ctrl_sva.sv]
`timescale 1ns/10ps
module afrc_ctrl_sva #(
    parameter afrc_pkg::afrc_coarse_lut_t COARSE_LUT = afrc_pkg::COARSE_LUT_DEF
) (
    input wire logic                         i_clk,
    input wire logic                         i_sys_rst,
    input wire logic                         i_black_level_sample_strobe,
    input wire logic                         i_video_sample_strobe,
    input wire logic                         i_line_clamp_gate,
    input wire logic [1:0]                   o_input_mux_sel,
    input wire logic                         o_reset_switch_a,
    input wire logic                         o_reset_switch_b,
    input wire logic                         o_reference_switch_a,
    input wire logic                         o_reference_switch_b,
    input wire logic                         o_video_track,
    input wire logic                         o_clamp_phase,
    input wire logic                         o_clamp_switch,
    input wire logic                         o_cr_dac_hiz,
    input wire logic [2:0]                   o_cr_dac_code,
    input wire afrc_pkg::afrc_offset_t [2:0] o_offset
);
    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    function automatic bit lut_ok(input logic [8:0] v);
        return v == COARSE_LUT[0] || v == COARSE_LUT[1] ||
            v == COARSE_LUT[2] || v == COARSE_LUT[3];
    endfunction

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_clamp_needs_black: assert property (
        o_clamp_phase |-> $past(i_black_level_sample_strobe))
        else $error("clamp phase without black strobe");
    a_clamp_gate_black: assert property (
        $past(i_black_level_sample_strobe) && $past(i_line_clamp_gate)
        |-> o_clamp_phase)
        else $error("clamp phase missing with gate and black");
    a_clamp_switch_gated: assert property (
        o_clamp_switch |-> o_clamp_phase)
        else $error("clamp switch closed outside clamp phase");
    a_ref_switch_follow: assert property (
        $rose(i_black_level_sample_strobe)
        |=> o_reference_switch_a && o_reference_switch_b)
        else $error("reference switches not closed by black strobe");
    a_video_hold: assert property (
        $fell(i_video_sample_strobe) |=> !o_video_track)
        else $error("video phase not released after sampling edge");
    a_reset_close: assert property (
        $rose(i_black_level_sample_strobe)
        |-> ##[1:3] (o_reset_switch_a && o_reset_switch_b))
        else $error("reset switches not closed at black lead");
    a_reset_open_late: assert property (
        $fell(i_video_sample_strobe) |-> o_reset_switch_a
        ##[1:4] (!o_reset_switch_a && !o_reset_switch_b))
        else $error("reset switches not opened after video sample");
    a_mux_step_valid: assert property (
        $changed(o_input_mux_sel) |-> o_input_mux_sel != 2'h3 &&
        (o_input_mux_sel == afrc_pkg::MUX_RED ||
        o_input_mux_sel == $past(o_input_mux_sel) + 2'h1))
        else $error("input mux stepped out of order");
    a_hiz_code_only: assert property (
        o_cr_dac_hiz |-> o_cr_dac_code == afrc_pkg::CR_HIZ_CODE)
        else $error("reference high-z with wrong code");
    a_coarse_in_lut: assert property (
        lut_ok(o_offset[0].coarse_mv) && lut_ok(o_offset[1].coarse_mv) &&
        lut_ok(o_offset[2].coarse_mv))
        else $error("coarse offset outside table");

    c_line_clamp: cover property ($rose(o_clamp_phase) && i_line_clamp_gate);
    c_clamp_switch: cover property (o_clamp_switch);
    c_ref_hiz: cover property (o_cr_dac_hiz);
    c_mux_blue: cover property (o_input_mux_sel == afrc_pkg::MUX_BLUE);
endmodule

// [sim/afrc_ctrl_test.sv]
`timescale 1ns/10ps
module afrc_ctrl_test;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam afrc_pkg::afrc_coarse_lut_t TB_LUT =
        {9'h000, 9'h0c8, 9'h064, 9'h19c};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        black = 1'b0, video = 1'b0, gate = 1'b0, adc = 1'b0;
    logic [7:0]  conv = 8'h00;
    logic        load_n, sclk, serial_data_in;
    logic [7:0]  data;
    logic [1:0]  mux;
    logic        rsw_a, rsw_b, rfs_a, rfs_b, vtrk, clamp, csw, hiz;
    logic [2:0]  crc;
    afrc_pkg::afrc_offset_t [2:0] ofs;
    logic [9:0]  regs [16];
    logic [9:0]  d;
    int          n_fail = 0, comparisons = 0, cyc = 0;

    afrc_ctrl #(.COARSE_LUT(TB_LUT)) i_dut (
        .i_clk(clk), .i_sys_rst(rst), .i_serial_load_n(load_n),
        .i_serial_clk(sclk), .i_serial_data_in(serial_data_in),
        .i_black_level_sample_strobe(black), .i_video_sample_strobe(video),
        .i_line_clamp_gate(gate), .i_adc_clk(adc), .i_conv_data(conv),
        .o_data_out(data), .o_input_mux_sel(mux), .o_reset_switch_a(rsw_a),
        .o_reset_switch_b(rsw_b), .o_reference_switch_a(rfs_a),
        .o_reference_switch_b(rfs_b), .o_video_track(vtrk),
        .o_clamp_phase(clamp), .o_clamp_switch(csw), .o_cr_dac_hiz(hiz),
        .o_cr_dac_code(crc), .o_offset(ofs));

    afrc_ctrl_host i_host (.i_clk(clk), .o_load_n(load_n), .o_sclk(sclk),
        .o_sdi(serial_data_in));

    initial
    begin
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [16:0] s,
        input logic [16:0] e);
        comparisons++;
        if (s !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    function automatic afrc_pkg::afrc_offset_t ofs_exp(input logic [9:0] v);
        return {TB_LUT[v[9:8]], v[7], v[6:0]};
    endfunction

    task automatic read_reg(input logic [3:0] a, input logic [9:0] v,
        input logic nib);
        logic [15:0] w;
        logic [7:0]  e;
        w = {6'h00, v};
        i_host.write_reg(afrc_pkg::ADDR_RESET_READ, {2'b01, 4'h0, a});
        for (int l = 0; l <= (nib ? 4 : 2); l++)
        begin
            if (l > 0)
            begin
                adc = 1'b1;
                @(negedge clk);
                adc = 1'b0;
            end
            repeat (3) @(negedge clk);
            e = nib ? {4'h0, w[15 - 4 * (l % 4) -: 4]}
                    : w[15 - 8 * (l % 2) -: 8];
            chk("readback", 17'(data), 17'(e));
        end
    endtask

    task automatic read_all(input logic nib);
        for (int p = 0; p < 16; p++)
        begin
            if (p != 12)
                read_reg(4'(p), regs[p], nib);
        end
        i_host.write_reg(afrc_pkg::ADDR_RESET_READ, 10'h000);
        conv = 8'($urandom);
        repeat (2) @(negedge clk);
        chk("conversion", 17'(data), 17'(conv));
    endtask

    task automatic pixel(input logic g, input logic [9:0] m);
        logic e;
        e = m[5] ? g : 1'b1;
        gate = g;
        black = 1'b1;
        repeat (3) @(negedge clk);
        chk("clamp", 17'(clamp), 17'(e));
        chk("clamp switch", 17'(csw), 17'(e & ~m[4]));
        chk("reference", 17'(rfs_a & rfs_b), 17'h1);
        black = 1'b0;
        repeat (2) @(negedge clk);
        video = 1'b1;
        repeat (2) @(negedge clk);
        chk("track", 17'(vtrk), 17'h1);
        video = 1'b0;
        repeat (4) @(negedge clk);
        chk("reset switch", 17'(rsw_a | rsw_b), 17'h0);
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(24));
        foreach (regs[i])
            regs[i] = 10'h000;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        for (int a = 0; a <= 10; a++)
        begin
            d = 10'($urandom);
            if (a == 6)
                d[3] = 1'b1;
            regs[a] = d;
            i_host.write_reg(4'(a), d);
            if (a >= 3 && a <= 5)
                chk("offset", 17'(ofs[a - 3]),
                    17'(ofs_exp(d)));
        end
        chk("dac code", 17'(crc), 17'(regs[6][2:0]));
        chk("hiz", 17'(hiz), 17'(regs[6][4] && regs[6][2:0] == 3'h7));
        read_all(1'b1);
        $display("test registers done");
        foreach (d[i])
        begin
            if (i < 2)
            begin
                regs[6] = (i == 0) ? 10'h01f : 10'h020;
                i_host.write_reg(afrc_pkg::ADDR_MODE_PRIMARY, regs[6]);
                chk("hiz", 17'(hiz), 17'(i == 0));
                repeat (4)
                    pixel(1'($urandom), regs[6]);
            end
        end
        $display("test clamp done");
        i_host.write_reg(afrc_pkg::ADDR_RESET_READ, 10'h200);
        foreach (regs[i])
            regs[i] = 10'h000;
        chk("mux", 17'(mux), 17'(afrc_pkg::MUX_RED));
        @(negedge clk);
        chk("offset", 17'(ofs[1]), 17'(ofs_exp(10'h000)));
        read_all(1'b0);
        read_reg(afrc_pkg::ADDR_RESET_READ, 10'h10c, 1'b0);
        $display("test soft reset done");
        end_sim();
    end
endmodule

bind afrc_ctrl afrc_ctrl_sva #(.COARSE_LUT(COARSE_LUT)) i_sva (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_black_level_sample_strobe(i_black_level_sample_strobe),
        .i_video_sample_strobe(i_video_sample_strobe),
        .i_line_clamp_gate(i_line_clamp_gate),
        .o_input_mux_sel(o_input_mux_sel),
        .o_reset_switch_a(o_reset_switch_a),
        .o_reset_switch_b(o_reset_switch_b),
        .o_reference_switch_a(o_reference_switch_a),
        .o_reference_switch_b(o_reference_switch_b),
        .o_video_track(o_video_track), .o_clamp_phase(o_clamp_phase),
        .o_clamp_switch(o_clamp_switch), .o_cr_dac_hiz(o_cr_dac_hiz),
        .o_cr_dac_code(o_cr_dac_code), .o_offset(o_offset));
